// file: design/msr_pkg.sv
package msr_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_FLAGS_LOW   = 8'h1d;
  localparam logic [7:0] IDX_FLAGS_HIGH  = 8'h1e;
  localparam logic [7:0] IDX_ACCEL       = 8'h1f;
  localparam logic [7:0] IDX_GYRO        = 8'h20;
  localparam logic [7:0] IDX_QUEUE       = 8'h21;
  localparam logic [7:0] IDX_WM_LOW      = 8'h22;
  localparam logic [7:0] IDX_WM_HIGH     = 8'h23;
  localparam logic [7:0] IDX_EN_LOW      = 8'h1a;
  localparam logic [7:0] IDX_EN_HIGH     = 8'h1b;
  localparam logic [7:0] IDX_IRQ_CFG     = 8'h1c;
  localparam logic [7:0] IDX_ACT_WM_LOW  = 8'h30;
  localparam logic [7:0] IDX_ACT_WM_HIGH = 8'h31;
  localparam logic [7:0] IDX_STATUS      = 8'h32;
  localparam int ADDR_LSB = 2;

  localparam logic [7:0] RST_ACCEL   = 8'h06;
  localparam logic [7:0] RST_GYRO    = 8'h06;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_EN_LOW  = 8'h80;
  localparam logic [7:0] RST_EN_HIGH = 8'h00;
  localparam logic [7:0] RST_IRQ_CFG = 8'h00;
  localparam logic [7:0] HIGH_MASK   = 8'h5f;
  localparam logic [7:0] ACCEL_MASK  = 8'h7f;

  localparam int BIT_RESET_DONE = 7;
  localparam int BIT_WM         = 1;
  localparam int BIT_FULL       = 0;
  localparam int BIT_CFG_LATCH  = 1;
  localparam int BIT_CFG_POL    = 0;

  localparam logic [1:0] MODE_BYPASS = 2'b00;
  localparam logic [1:0] MODE_STREAM = 2'b01;
  localparam logic [1:0] MODE_STOP   = 2'b10;
  localparam logic [1:0] MODE_RSVD   = 2'b11;
  localparam logic [5:0] DEPTH_2K    = 6'b00_0111;
  localparam logic [5:0] DEPTH_4K    = 6'b00_1111;
  localparam logic [15:0] BYTES_2K   = 16'h0800;
  localparam logic [15:0] BYTES_4K   = 16'h1000;
  localparam logic [2:0] ACCEL_FS_MAX = 3'h4;
  localparam logic [3:0] GYRO_FS_MAX  = 4'h8;
  localparam logic [3:0] ODR_LN_LAST  = 4'h6;
  localparam logic [3:0] ODR_LP_FIRST = 4'hd;
endpackage

// file: design/msr_status_bits.sv
`timescale 1ns/1ps
// One bank of read-to-clear flags; a set in the clearing cycle wins.
module msr_status_bits #(
  parameter int         W    = 8,
  parameter logic [7:0] MASK = 8'hff
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] enable_i,
  input  wire logic         clear_i,
  output logic      [W-1:0] flags_q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          flags_q[i] <= 1'b0;
        end else if (MASK[i] && enable_i[i] && set_i[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clear_i) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // msr_status_bits

// file: design/msr_regs.sv
`timescale 1ns/1ps
module msr_regs (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fuse_copy_done,
  input  wire logic [6:0]  low_events,
  input  wire logic [7:0]  high_events,
  input  wire logic [15:0] queue_level,
  input  wire logic        queue_frame_fits,
  output logic             irq_out,
  output logic [2:0]       accel_range_select,
  output logic [3:0]       accel_rate_code,
  output logic [3:0]       gyro_range_select,
  output logic [3:0]       gyro_rate_code,
  output logic             queue_enable,
  output logic             queue_overwrite,
  output logic             queue_cfg_error,
  output logic [15:0]      queue_capacity,
  output logic [15:0]      buffer_watermark_level
);
  logic [7:0]  accel_q, gyro_q, queue_q, wm_low_q, wm_high_q;
  logic [7:0]  en_low_q, en_high_q, cfg_q;
  logic [15:0] wm_active_q;
  logic [7:0]  flags_low_q, flags_high_q, set_low;
  logic        fuse_seen_q, pend_clear_q, irq_state_q, pulse_q;
  logic        acc, wr, rd;
  logic [7:0]  idx, wbyte;
  logic        wm_hit;

  function automatic logic [15:0] depth_bytes(input logic [5:0] d);
    depth_bytes = (d == msr_pkg::DEPTH_4K) ? msr_pkg::BYTES_4K :
                  msr_pkg::BYTES_2K;
  endfunction

  function automatic logic is_reg(input logic [7:0] i);
    unique case (i)
      msr_pkg::IDX_FLAGS_LOW, msr_pkg::IDX_FLAGS_HIGH, msr_pkg::IDX_ACCEL,
      msr_pkg::IDX_GYRO, msr_pkg::IDX_QUEUE, msr_pkg::IDX_WM_LOW,
      msr_pkg::IDX_WM_HIGH, msr_pkg::IDX_EN_LOW, msr_pkg::IDX_EN_HIGH,
      msr_pkg::IDX_IRQ_CFG, msr_pkg::IDX_ACT_WM_LOW,
      msr_pkg::IDX_ACT_WM_HIGH, msr_pkg::IDX_STATUS: is_reg = 1'b1;
      default: is_reg = 1'b0;
    endcase
  endfunction

  assign idx   = paddr[msr_pkg::ADDR_LSB +: 8];
  assign acc   = psel && penable && pready;
  assign wr    = acc && pwrite && pstrb[0] && is_reg(idx);
  assign rd    = acc && !pwrite && is_reg(idx);
  assign wbyte = pwdata[7:0];

  // One wait state: pready rises in the second access cycle for one cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_reg(idx);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= '0;
      unique case (idx)
        msr_pkg::IDX_FLAGS_LOW:   prdata[7:0] <= flags_low_q;
        msr_pkg::IDX_FLAGS_HIGH:  prdata[7:0] <= flags_high_q;
        msr_pkg::IDX_ACCEL:       prdata[7:0] <= accel_q;
        msr_pkg::IDX_GYRO:        prdata[7:0] <= gyro_q;
        msr_pkg::IDX_QUEUE:       prdata[7:0] <= queue_q;
        msr_pkg::IDX_WM_LOW:      prdata[7:0] <= wm_low_q;
        msr_pkg::IDX_WM_HIGH:     prdata[7:0] <= wm_high_q;
        msr_pkg::IDX_EN_LOW:      prdata[7:0] <= en_low_q;
        msr_pkg::IDX_EN_HIGH:     prdata[7:0] <= en_high_q;
        msr_pkg::IDX_IRQ_CFG:     prdata[7:0] <= cfg_q;
        msr_pkg::IDX_ACT_WM_LOW:  prdata[7:0] <= wm_active_q[7:0];
        msr_pkg::IDX_ACT_WM_HIGH: prdata[7:0] <= wm_active_q[15:8];
        msr_pkg::IDX_STATUS:      prdata[7:0] <= {6'd0, pend_clear_q,
                                                  irq_state_q};
        default:                  prdata <= '0;
      endcase
    end
  end

  // Configuration writes take effect at the accepting edge.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      accel_q   <= msr_pkg::RST_ACCEL;
      gyro_q    <= msr_pkg::RST_GYRO;
      queue_q   <= msr_pkg::RST_ZERO;
      wm_low_q  <= msr_pkg::RST_ZERO;
      wm_high_q <= msr_pkg::RST_ZERO;
      en_low_q  <= msr_pkg::RST_EN_LOW;
      en_high_q <= msr_pkg::RST_EN_HIGH;
      cfg_q     <= msr_pkg::RST_IRQ_CFG;
    end else if (wr) begin
      unique case (idx)
        msr_pkg::IDX_ACCEL:   accel_q <= wbyte & msr_pkg::ACCEL_MASK;
        msr_pkg::IDX_GYRO:    gyro_q <= wbyte;
        msr_pkg::IDX_QUEUE:   queue_q <= wbyte;
        msr_pkg::IDX_WM_LOW:  wm_low_q <= wbyte;
        msr_pkg::IDX_WM_HIGH: wm_high_q <= wbyte;
        msr_pkg::IDX_EN_LOW:  en_low_q <= wbyte;
        msr_pkg::IDX_EN_HIGH: en_high_q <= wbyte & msr_pkg::HIGH_MASK;
        msr_pkg::IDX_IRQ_CFG: cfg_q <= wbyte;
        default: ;
      endcase
    end
  end

  // The active threshold moves only on the high-byte strobe.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wm_active_q <= '0;
    end else if (wr && idx == msr_pkg::IDX_WM_HIGH) begin
      wm_active_q <= {wbyte, wm_low_q};
    end
  end

  // The high-byte strobe checks the level against the new threshold.
  assign wm_hit = (wr && idx == msr_pkg::IDX_WM_HIGH &&
                   {wbyte, wm_low_q} != '0 &&
                   queue_level >= {wbyte, wm_low_q}) ||
                  (wm_active_q != '0 && queue_level >= wm_active_q);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fuse_seen_q <= 1'b0;
    end else begin
      fuse_seen_q <= fuse_copy_done;
    end
  end

  always_comb begin
    set_low = {1'b0, low_events};
    set_low[msr_pkg::BIT_RESET_DONE] = fuse_copy_done && !fuse_seen_q;
    set_low[msr_pkg::BIT_WM] = low_events[msr_pkg::BIT_WM] || wm_hit;
    set_low[msr_pkg::BIT_FULL] = low_events[msr_pkg::BIT_FULL] &&
                                 queue_enable;
  end

  msr_status_bits #(.W(8), .MASK(8'hff)) u_low (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .set_i    (set_low),
    .enable_i (en_low_q),
    .clear_i  (rd && idx == msr_pkg::IDX_FLAGS_LOW),
    .flags_q  (flags_low_q)
  );

  msr_status_bits #(.W(8), .MASK(msr_pkg::HIGH_MASK)) u_high (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .set_i    (high_events),
    .enable_i (en_high_q),
    .clear_i  (rd && idx == msr_pkg::IDX_FLAGS_HIGH),
    .flags_q  (flags_high_q)
  );

  // A low-register read arms release; a read of any other register clears it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_clear_q <= 1'b0;
    end else if (rd && idx == msr_pkg::IDX_FLAGS_LOW) begin
      pend_clear_q <= 1'b1;
    end else if (rd) begin
      pend_clear_q <= 1'b0;
    end
  end

  // Latched state follows any standing flag; pulse fires on a new rise.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_state_q <= 1'b0;
      pulse_q     <= 1'b0;
    end else begin
      irq_state_q <= (|flags_low_q) || (|flags_high_q);
      pulse_q     <= ((|flags_low_q) || (|flags_high_q)) && !irq_state_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (cfg_q[msr_pkg::BIT_CFG_LATCH] ? irq_state_q : pulse_q)
                 ^ !cfg_q[msr_pkg::BIT_CFG_POL];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      accel_range_select     <= msr_pkg::RST_ACCEL[6:4];
      accel_rate_code        <= msr_pkg::RST_ACCEL[3:0];
      gyro_range_select      <= msr_pkg::RST_GYRO[7:4];
      gyro_rate_code         <= msr_pkg::RST_GYRO[3:0];
      queue_enable           <= 1'b0;
      queue_overwrite        <= 1'b0;
      queue_cfg_error        <= 1'b0;
      queue_capacity         <= msr_pkg::BYTES_2K;
      buffer_watermark_level <= '0;
    end else begin
      accel_range_select <= accel_q[6:4];
      accel_rate_code    <= accel_q[3:0];
      gyro_range_select  <= gyro_q[7:4];
      gyro_rate_code     <= gyro_q[3:0];
      queue_enable <= queue_q[7:6] == msr_pkg::MODE_STREAM ||
                      queue_q[7:6] == msr_pkg::MODE_STOP;
      queue_overwrite <= queue_q[7:6] == msr_pkg::MODE_STREAM &&
                         queue_frame_fits;
      queue_cfg_error <= queue_q[7:6] == msr_pkg::MODE_RSVD ||
                         (queue_q[5:0] != msr_pkg::DEPTH_2K &&
                          queue_q[5:0] != msr_pkg::DEPTH_4K) ||
                         accel_q[6:4] > msr_pkg::ACCEL_FS_MAX ||
                         gyro_q[7:4] > msr_pkg::GYRO_FS_MAX;
      queue_capacity <= depth_bytes(queue_q[5:0]);
      buffer_watermark_level <= wm_active_q;
    end
  end

  wm_commit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && idx == msr_pkg::IDX_WM_LOW) ##1 (!wr)[*2]
    |-> wm_active_q == $past(wm_active_q, 2))
    else $error("threshold changed without high byte write");
  wm_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && idx == msr_pkg::IDX_WM_HIGH) |=> ##1
    buffer_watermark_level == $past(wm_active_q))
    else $error("threshold output not updated");
  low_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd && idx == msr_pkg::IDX_FLAGS_LOW && set_low == '0 && !wm_hit)
    |=> flags_low_q == '0)
    else $error("low flags not cleared by read");
  rsvd_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flags_high_q & ~msr_pkg::HIGH_MASK) == '0)
    else $error("reserved high flag set");
  dis_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> (flags_low_q & ~$past(flags_low_q) & ~$past(en_low_q)) == '0)
    else $error("disabled source raised flag");
  done_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(fuse_copy_done) && en_low_q[msr_pkg::BIT_RESET_DONE]
    |=> flags_low_q[msr_pkg::BIT_RESET_DONE])
    else $error("reset complete flag not set");
  rate_live_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && idx == msr_pkg::IDX_ACCEL) |=> ##1
    accel_rate_code == $past(wbyte[3:0], 2))
    else $error("accel rate not applied");
  bypass_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    queue_q[7:6] == msr_pkg::MODE_BYPASS |=> !queue_enable)
    else $error("queue enabled in bypass");
  latch_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_q[msr_pkg::BIT_CFG_LATCH] && $stable(cfg_q) && irq_state_q
    |=> irq_out == cfg_q[msr_pkg::BIT_CFG_POL])
    else $error("latched pin not active");
  wm_event_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wm_hit && en_low_q[msr_pkg::BIT_WM] |=> flags_low_q[msr_pkg::BIT_WM])
    else $error("watermark event missed");
endmodule // msr_regs

// file: test/msr_host.sv
`timescale 1ns/1ps
// Host-side APB master; holds each request until pready is sampled high or 50 access cycles pass.
module msr_host (
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd,
                      output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    pstrb  <= 4'hf;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines carry junk so a stale address is never relied on.
    paddr  <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // msr_host

// file: test/motion_sensor_irq_fifo_cfg_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin \
  error_cnt++; $display("[ERR] %0t %s", $time, m); end end
module motion_sensor_irq_fifo_cfg_regs_tb;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        fuse_copy_done, queue_frame_fits, irq_out, err;
  logic        queue_enable, queue_overwrite, queue_cfg_error;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, accel_rate_code, gyro_range_select, gyro_rate_code;
  logic [2:0]  accel_range_select;
  logic [6:0]  low_events;
  logic [7:0]  high_events, rd, a, g, lo, hi;
  logic [5:0]  q;
  logic [15:0] queue_level, queue_capacity, buffer_watermark_level, w, pw;
  int          error_cnt, n_compared, k;

  msr_host u_msr_host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  msr_regs u_msr_regs (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_copy_done(fuse_copy_done), .low_events(low_events),
    .high_events(high_events), .queue_level(queue_level),
    .queue_frame_fits(queue_frame_fits), .irq_out(irq_out),
    .accel_range_select(accel_range_select),
    .accel_rate_code(accel_rate_code), .gyro_range_select(gyro_range_select),
    .gyro_rate_code(gyro_rate_code), .queue_enable(queue_enable),
    .queue_overwrite(queue_overwrite), .queue_cfg_error(queue_cfg_error),
    .queue_capacity(queue_capacity),
    .buffer_watermark_level(buffer_watermark_level));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] r;
    logic       e;
    u_msr_host.xfer(1'b1, idx, v, r, e);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] ev, string m);
    u_msr_host.xfer(1'b0, idx, 8'h00, rd, err);
    `CHK(rd, ev, m)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(input logic [6:0] l, input logic [7:0] h);
    @(posedge core_clk);
    low_events <= l;
    high_events <= h;
    @(posedge core_clk);
    low_events <= 7'h00;
    high_events <= 8'h00;
  endtask

  function automatic logic [15:0] cap_of(input logic [5:0] d);
    return (d == msr_pkg::DEPTH_4K) ? msr_pkg::BYTES_4K : msr_pkg::BYTES_2K;
  endfunction

  initial begin
    #(100 * 20000);
    error_cnt++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    {fuse_copy_done, low_events, high_events} = 16'h0000;
    queue_level = 16'h0000;
    queue_frame_fits = 1'b1;
    void'($urandom(52));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(msr_pkg::IDX_ACCEL, msr_pkg::RST_ACCEL, "accel reset");
    rdc(msr_pkg::IDX_GYRO, msr_pkg::RST_GYRO, "gyro reset");
    rdc(msr_pkg::IDX_QUEUE, 8'h00, "queue reset");
    rdc(msr_pkg::IDX_WM_HIGH, 8'h00, "wm reset");
    @(posedge core_clk);
    fuse_copy_done <= 1'b1;
    rdc(msr_pkg::IDX_FLAGS_LOW, 8'h80, "reset done set");
    rdc(msr_pkg::IDX_FLAGS_LOW, 8'h00, "reset done clear");
    u_msr_host.xfer(1'b1, 8'h3f, 8'h55, rd, err);
    `CHK(err, 1'b1, "unmapped error")
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom);
      a[6:4] = 3'($urandom_range(4));
      g = (i == 0) ? 8'h8f : {4'($urandom_range(8)), 4'($urandom)};
      wr(msr_pkg::IDX_ACCEL, a);
      wr(msr_pkg::IDX_GYRO, g);
      rdc(msr_pkg::IDX_ACCEL, a & msr_pkg::ACCEL_MASK, "accel rb");
      rdc(msr_pkg::IDX_GYRO, g, "gyro rb");
      settle(1);
      `CHK(accel_range_select, a[6:4], "accel range")
      `CHK(accel_rate_code, a[3:0], "accel rate")
      `CHK(gyro_range_select, g[7:4], "gyro range")
      `CHK(gyro_rate_code, g[3:0], "gyro rate")
    end
    for (int m = 0; m < 6; m++) begin
      q = m[0] ? msr_pkg::DEPTH_4K : msr_pkg::DEPTH_2K;
      queue_frame_fits <= (m != 3);
      wr(msr_pkg::IDX_QUEUE, {2'b00, q});
      wr(msr_pkg::IDX_QUEUE, {m[2:1], q});
      settle(3);
      `CHK(queue_enable, 1'(m > 1), "queue enable")
      `CHK(queue_overwrite, 1'(m == 2), "overwrite")
      `CHK(queue_capacity, cap_of(q), "capacity")
      `CHK(queue_cfg_error, 1'b0, "cfg ok")
    end
    wr(msr_pkg::IDX_QUEUE, 8'hc7);
    settle(3);
    `CHK(queue_cfg_error, 1'b1, "reserved mode")
    wr(msr_pkg::IDX_QUEUE, 8'h07);
    pulse(7'h00, 8'hff);
    rdc(msr_pkg::IDX_FLAGS_HIGH, 8'h00, "disabled source");
    wr(msr_pkg::IDX_EN_HIGH, msr_pkg::HIGH_MASK);
    wr(msr_pkg::IDX_EN_LOW, 8'hfe);
    for (int p = 0; p < 2; p++) begin
      wr(msr_pkg::IDX_IRQ_CFG, {6'h00, 1'b1, p[0]});
      lo = (8'($urandom) & 8'h7c) | 8'h04;
      hi = 8'($urandom) | 8'h01;
      pulse(lo[6:0], hi);
      settle(3);
      `CHK(irq_out, p[0], "irq active")
      rdc(msr_pkg::IDX_FLAGS_LOW, lo, "low flags");
      rdc(msr_pkg::IDX_FLAGS_HIGH, hi & msr_pkg::HIGH_MASK, "hi");
      settle(3);
      `CHK(irq_out, ~p[0], "irq released")
    end
    wr(msr_pkg::IDX_IRQ_CFG, 8'h01);
    pulse(7'h04, 8'h00);
    k = 0;
    repeat (8) begin
      settle(1);
      k += int'(irq_out === 1'b1);
    end
    `CHK(k, 1, "pulse width")
    rdc(msr_pkg::IDX_FLAGS_LOW, 8'h04, "pulse flag");
    wr(msr_pkg::IDX_EN_LOW, 8'h82);
    pw = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 16'h0800 : (i == 1) ? 16'h0000 : 16'($urandom_range(300, 1));
      @(posedge core_clk);
      queue_level <= (i == 0) ? 16'h07ff : (i == 1) ? 16'h0005 : 16'h012c;
      wr(msr_pkg::IDX_WM_LOW, w[7:0]);
      settle(2);
      `CHK(buffer_watermark_level, pw, "early")
      wr(msr_pkg::IDX_WM_HIGH, w[15:8]);
      settle(3);
      `CHK(buffer_watermark_level, w, "commit")
      pw = w;
      @(posedge core_clk);
      queue_level <= 16'h0000;
      rdc(msr_pkg::IDX_FLAGS_LOW, (i == 2) ? 8'h02 : 8'h00, "wm");
    end
    rdc(msr_pkg::IDX_FLAGS_LOW, 8'h00, "wm cleared");
    finish_test();
  end
endmodule // motion_sensor_irq_fifo_cfg_regs_tb
